// [verilog/ebusr_core.sv]
// Eight-bit universal shift register with selectable personality.
`timescale 1ns/100ps
module ebusr_core
    import ebusr_pkg::*;
#(
    parameter bit UNIDIR = 1'b0
)
(
    // Clock and reset
    input  wire logic       i_mclk,
    input  wire logic       i_rst_b,
    // Register clear, active low
    input  wire logic       i_clear_b,
    // Bidirectional clock and mode selects
    input  wire logic       i_shift_clk,
    input  wire logic       i_mode_sel_zero,
    input  wire logic       i_mode_sel_one,
    // Bidirectional serial entries
    input  wire logic       i_ser_right,
    input  wire logic       i_ser_left,
    // Unidirectional gated clocks and controls
    input  wire logic       i_gate_clk_a,
    input  wire logic       i_gate_clk_b,
    input  wire logic       i_shift_load,
    input  wire logic       i_ser_j,
    input  wire logic       i_ser_k_b,
    // Parallel data in, bit 0 feeds the first stage
    input  wire logic [7:0] i_par_data,
    // Stage outputs
    output wire logic [7:0] o_stage,
    output wire logic       o_first_stage_out,
    output wire logic       o_last_stage_out,
    // Word stream of every committed stage update
    output wire logic       o_word_valid,
    output wire logic [7:0] o_word_data,
    input  wire logic       i_word_ready,
    // Stall and overrun status
    output wire logic       o_stalled,
    output wire logic       o_overrun
);

    // ------------------------------------------------------------------
    // Shift helpers
    // ------------------------------------------------------------------

    // Moves every stage one place toward the last stage.
    function automatic logic [7:0] shift_to_last(input logic [7:0] word,
                                                 input logic       enter);
        shift_to_last = {word[6:0], enter};
    endfunction

    // Moves every stage one place toward the first stage.
    function automatic logic [7:0] shift_to_first(input logic [7:0] word,
                                                  input logic       enter);
        shift_to_first = {enter, word[7:1]};
    endfunction

    // Next first stage from the J and inverted-K serial entry.
    // Both low clears, both high sets, J low keeps and J high toggles.
    function automatic logic jk_entry(input logic j,
                                      input logic k_b,
                                      input logic cur);
        jk_entry = (j & ~cur) | (k_b & cur);
    endfunction

    // ------------------------------------------------------------------
    // Pin synchroniser
    // ------------------------------------------------------------------

    // The clock bits of the synchroniser and the edge detector reset
    // high, so a clock pin that is already high when reset ends is not
    // taken for a rising edge once the synchronised clear lets go.
    logic [18:0] pin_meta;
    logic [18:0] pin_sync;

    wire  [18:0] pin_raw = {i_clear_b,
                            i_shift_clk,
                            i_gate_clk_a,
                            i_gate_clk_b,
                            i_mode_sel_one,
                            i_mode_sel_zero,
                            i_shift_load,
                            i_ser_j,
                            i_ser_k_b,
                            i_ser_right,
                            i_ser_left,
                            i_par_data};

    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            pin_meta <= EBUSR_PIN_RST;
            pin_sync <= EBUSR_PIN_RST;
        end else begin
            pin_meta <= pin_raw;
            pin_sync <= pin_meta;
        end
    end

    wire       s_clear_b = pin_sync[EBUSR_PIN_CLRB];
    wire       s_clk     = pin_sync[EBUSR_PIN_CLK];
    wire       s_clk_a   = pin_sync[EBUSR_PIN_CLKA];
    wire       s_clk_b   = pin_sync[EBUSR_PIN_CLKB];
    wire       s_sel_one = pin_sync[EBUSR_PIN_SEL1];
    wire       s_sel_zero = pin_sync[EBUSR_PIN_SEL0];
    wire       s_shld    = pin_sync[EBUSR_PIN_SHLD];
    wire       s_j       = pin_sync[EBUSR_PIN_J];
    wire       s_k_b     = pin_sync[EBUSR_PIN_KB];
    wire       s_right   = pin_sync[EBUSR_PIN_RIGHT];
    wire       s_left    = pin_sync[EBUSR_PIN_LEFT];
    wire [7:0] s_data    = pin_sync[EBUSR_PIN_DATA_LSB +: EBUSR_STAGES];

    // ------------------------------------------------------------------
    // Clock edge detection
    // ------------------------------------------------------------------

    // A pin change reaches the stages on the second system clock edge
    // after the one that first samples it, so pins must stay steady that long.

    // The gated clock is the OR of both inputs, so either may be clock
    // or inhibit and a high inhibit leaves no rising edge to act on.
    wire  gated_clk  = s_clk_a | s_clk_b;
    wire  active_clk = UNIDIR ? gated_clk : s_clk;

    logic clk_prev;

    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            clk_prev <= EBUSR_CLK_IDLE;
        end else begin
            clk_prev <= active_clk;
        end
    end

    wire clk_edge = active_clk & ~clk_prev;

    // ------------------------------------------------------------------
    // Clear qualification
    // ------------------------------------------------------------------

    // An edge that falls while clear is active is ignored, so clear
    // overrides the clock and the release of clear never clocks.
    wire clear_on = ~s_clear_b;
    wire clk_rise = clk_edge & ~clear_on;

    // ------------------------------------------------------------------
    // Mode decode
    // ------------------------------------------------------------------

    wire       bi_hold  = ~s_sel_one & ~s_sel_zero;
    wire       bi_right = ~s_sel_one & s_sel_zero;
    wire       bi_left  = s_sel_one & ~s_sel_zero;
    wire       bi_load  = s_sel_one & s_sel_zero;
    wire [3:0] bi_code  = {bi_load, bi_left, bi_right, bi_hold};
    wire [3:0] uni_code = s_shld ? EBUSR_MODE_RIGHT : EBUSR_MODE_LOAD;

    // Both personalities decode to one one-hot mode for a single datapath.
    ebusr_mode_e mode;
    assign mode = ebusr_mode_e'(UNIDIR ? uni_code : bi_code);

    // ------------------------------------------------------------------
    // Candidate stage value
    // ------------------------------------------------------------------

    logic [7:0] stage;
    logic [7:0] cand;

    wire right_entry = UNIDIR ? jk_entry(s_j, s_k_b, stage[0]) : s_right;

    // Each mode's candidate is formed apart and the mode selects one.
    wire [7:0] cand_hold  = stage;
    wire [7:0] cand_right = shift_to_last(stage, right_entry);
    wire [7:0] cand_left  = shift_to_first(stage, s_left);
    wire [7:0] cand_load  = s_data;

    always_comb begin
        unique case (mode)
            EBUSR_MODE_HOLD:  cand = cand_hold;
            EBUSR_MODE_RIGHT: cand = cand_right;
            EBUSR_MODE_LEFT:  cand = cand_left;
            EBUSR_MODE_LOAD:  cand = cand_load;
            default:          cand = stage;
        endcase
    end

    // A hold edge neither changes the stages nor sends a word.
    wire edge_upd = clk_rise & (mode != EBUSR_MODE_HOLD);

    // ------------------------------------------------------------------
    // Commit and stall control
    // ------------------------------------------------------------------

    logic       pend_valid;
    logic [7:0] pend_word;
    logic       overrun;
    wire        buf_ready;

    // A full buffer parks the update; stages move only once it is sent.
    // An edge that meets a parked update is dropped and flagged.
    wire        commit_pend   = pend_valid & buf_ready;
    wire        commit_direct = edge_upd & ~pend_valid & buf_ready;
    wire        commit_now    = (commit_pend | commit_direct) & ~clear_on;
    wire  [7:0] commit_word   = pend_valid ? pend_word : cand;
    wire        park          = edge_upd & ~pend_valid & ~buf_ready;
    wire        drop          = edge_upd & pend_valid;

    wire  [7:0] next_stage      = commit_now ? commit_word : stage;
    wire        next_pend_valid = park | (pend_valid & ~buf_ready);
    wire  [7:0] next_pend_word  = park ? cand : pend_word;

    // ------------------------------------------------------------------
    // Stage register
    // ------------------------------------------------------------------

    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            stage <= EBUSR_STAGE_RST;
        end else if (clear_on) begin
            stage <= EBUSR_STAGE_RST;
        end else begin
            stage <= next_stage;
        end
    end

    // ------------------------------------------------------------------
    // Parked update
    // ------------------------------------------------------------------

    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            pend_valid <= EBUSR_FLAG_RST;
            pend_word  <= EBUSR_STAGE_RST;
        end else if (clear_on) begin
            pend_valid <= EBUSR_FLAG_RST;
            pend_word  <= EBUSR_STAGE_RST;
        end else begin
            pend_valid <= next_pend_valid;
            pend_word  <= next_pend_word;
        end
    end

    // ------------------------------------------------------------------
    // Overrun flag
    // ------------------------------------------------------------------

    // An edge that arrives while an update is parked is lost; this flag
    // stays set until the next clear.
    wire next_overrun = overrun | drop;

    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            overrun <= EBUSR_FLAG_RST;
        end else if (clear_on) begin
            overrun <= EBUSR_FLAG_RST;
        end else begin
            overrun <= next_overrun;
        end
    end

    // ------------------------------------------------------------------
    // Output word buffer
    // ------------------------------------------------------------------

    // Clear leaves words already in the buffer for the sink; only the
    // stages and the parked update are emptied and the overrun flag cleared.
    ebusr_buf2 u_buf (
        .i_mclk      (i_mclk),
        .i_rst_b     (i_rst_b),
        .i_in_valid  (commit_now),
        .i_in_data   (commit_word),
        .o_in_ready  (buf_ready),
        .o_out_valid (o_word_valid),
        .o_out_data  (o_word_data),
        .i_out_ready (i_word_ready)
    );

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------

    // Every stage output is a bit of the stage register itself.
    assign o_stage           = stage;
    assign o_first_stage_out = stage[0];
    assign o_last_stage_out  = stage[EBUSR_STAGES-1];
    assign o_stalled         = pend_valid;
    assign o_overrun         = overrun;

endmodule

// [verilog/ebusr_pkg.sv]
// Shared constants and types of the eight-bit universal shift register.
package ebusr_pkg;

    // ------------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------------
    localparam int EBUSR_STAGES = 8;
    localparam int EBUSR_PIN_W  = 19;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [7:0]  EBUSR_STAGE_RST = 8'h00;
    localparam logic [18:0] EBUSR_PIN_RST   = 19'h38000;
    localparam logic        EBUSR_FLAG_RST  = 1'b0;
    localparam logic        EBUSR_CLK_IDLE  = 1'b1;

    // ------------------------------------------------------------------
    // Field positions inside the synchronised pin vector
    // ------------------------------------------------------------------
    localparam int EBUSR_PIN_DATA_LSB = 0;
    localparam int EBUSR_PIN_LEFT     = 8;
    localparam int EBUSR_PIN_RIGHT    = 9;
    localparam int EBUSR_PIN_KB       = 10;
    localparam int EBUSR_PIN_J        = 11;
    localparam int EBUSR_PIN_SHLD     = 12;
    localparam int EBUSR_PIN_SEL0     = 13;
    localparam int EBUSR_PIN_SEL1     = 14;
    localparam int EBUSR_PIN_CLKB     = 15;
    localparam int EBUSR_PIN_CLKA     = 16;
    localparam int EBUSR_PIN_CLK      = 17;
    localparam int EBUSR_PIN_CLRB     = 18;

    // ------------------------------------------------------------------
    // Operating modes, one-hot
    // ------------------------------------------------------------------
    typedef enum logic [3:0] {
        EBUSR_MODE_HOLD  = 4'h1,
        EBUSR_MODE_RIGHT = 4'h2,
        EBUSR_MODE_LEFT  = 4'h4,
        EBUSR_MODE_LOAD  = 4'h8
    } ebusr_mode_e;

endpackage

// [verilog/ebusr_buf2.sv]
// Two-entry buffer with valid and ready on both sides.
`timescale 1ns/100ps
module ebusr_buf2
    import ebusr_pkg::*;
(
    // Clock and reset
    input  wire logic       i_mclk,
    input  wire logic       i_rst_b,
    // Filling side
    input  wire logic       i_in_valid,
    input  wire logic [7:0] i_in_data,
    output wire logic       o_in_ready,
    // Draining side
    output wire logic       o_out_valid,
    output wire logic [7:0] o_out_data,
    input  wire logic       i_out_ready
);

    logic [7:0] head;
    logic [7:0] tail;
    logic       head_valid;
    logic       tail_valid;

    wire        pop          = head_valid & i_out_ready;
    wire        push         = i_in_valid & ~tail_valid;
    wire        after_pop_hv = pop ? tail_valid : head_valid;
    wire  [7:0] after_pop_h  = pop ? tail : head;
    wire        after_pop_tv = pop ? 1'b0 : tail_valid;
    wire        push_to_head = push & ~after_pop_hv;
    wire        push_to_tail = push & after_pop_hv;

    wire        next_head_valid = after_pop_hv | push_to_head;
    wire  [7:0] next_head       = push_to_head ? i_in_data : after_pop_h;
    wire        next_tail_valid = after_pop_tv | push_to_tail;
    wire  [7:0] next_tail       = push_to_tail ? i_in_data : tail;

    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            head_valid <= EBUSR_FLAG_RST;
            tail_valid <= EBUSR_FLAG_RST;
            head       <= EBUSR_STAGE_RST;
            tail       <= EBUSR_STAGE_RST;
        end else begin
            head_valid <= next_head_valid;
            tail_valid <= next_tail_valid;
            head       <= next_head;
            tail       <= next_tail;
        end
    end

    assign o_in_ready  = ~tail_valid;
    assign o_out_valid = head_valid;
    assign o_out_data  = head;

endmodule

// [test/ebusr_core_assertions.sv]
// Port-level checker for the eight-bit universal shift register.
`timescale 1ns/100ps
module ebusr_core_assertions
    import ebusr_pkg::*;
#(
    parameter bit UNIDIR = 1'b0
)
(
    // Watched ports
    input wire logic       i_mclk,
    input wire logic       i_rst_b,
    input wire logic       i_clear_b,
    input wire logic       i_shift_clk,
    input wire logic       i_mode_sel_zero,
    input wire logic       i_mode_sel_one,
    input wire logic       i_ser_right,
    input wire logic       i_ser_left,
    input wire logic       i_gate_clk_a,
    input wire logic       i_gate_clk_b,
    input wire logic       i_shift_load,
    input wire logic       i_ser_j,
    input wire logic       i_ser_k_b,
    input wire logic [7:0] i_par_data,
    input wire logic [7:0] o_stage,
    input wire logic       o_word_valid,
    input wire logic [7:0] o_word_data,
    input wire logic       i_word_ready,
    input wire logic       o_stalled,
    input wire logic       o_overrun
);
    // ------------------------------------------------------------------
    // Edge and mode decode
    // ------------------------------------------------------------------
    logic      act_q;
    wire logic act  = UNIDIR ? (i_gate_clk_a | i_gate_clk_b) : i_shift_clk;
    wire logic hold = !UNIDIR && !i_mode_sel_zero && !i_mode_sel_one;
    wire logic ld   = UNIDIR ? !i_shift_load : (i_mode_sel_zero && i_mode_sel_one);
    wire logic pend = act && !act_q && !hold;
    wire logic edg  = pend && !o_stalled && i_word_ready;
    wire logic jk   = i_ser_j ? (i_ser_k_b || !o_stage[0]) : (i_ser_k_b && o_stage[0]);

    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) act_q <= 1'b1;
        else act_q <= act;
    end

    default clocking @(posedge i_mclk); endclocking
    default disable iff (!i_rst_b || !i_clear_b);

    // ------------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------------
    property p_load;
        edg && ld |-> ##3 o_stage == $past(i_par_data, 3);
    endproperty
    a_load: assert property (p_load) else $error("load mismatch");
    property p_right;
        edg && !UNIDIR && i_mode_sel_zero && !i_mode_sel_one
            |-> ##3 o_stage == {$past(o_stage[6:0]), $past(i_ser_right, 3)};
    endproperty
    a_right: assert property (p_right) else $error("shift toward last wrong");
    property p_left;
        edg && !UNIDIR && !i_mode_sel_zero && i_mode_sel_one
            |-> ##3 o_stage == {$past(i_ser_left, 3), $past(o_stage[7:1])};
    endproperty
    a_left: assert property (p_left) else $error("shift toward first wrong");
    property p_uni;
        edg && UNIDIR && i_shift_load |-> ##3 o_stage == {$past(o_stage[6:0]), $past(jk, 3)};
    endproperty
    a_uni: assert property (p_uni) else $error("serial entry wrong");
    property p_hold;
        (!pend && !o_stalled)[*3] |=> $stable(o_stage);
    endproperty
    a_hold: assert property (p_hold) else $error("stage moved without edge");
    property p_clear;
        disable iff (!i_rst_b) !i_clear_b[*3] |=> o_stage == 8'h00 && !o_overrun && !o_stalled;
    endproperty
    a_clear: assert property (p_clear) else $error("clear not applied");
    property p_early;
        edg |=> $stable(o_stage)[*2];
    endproperty
    a_early: assert property (p_early) else $error("stage moved early");
    property p_word;
        edg |-> ##3 o_word_valid && o_word_data == o_stage;
    endproperty
    a_word: assert property (p_word) else $error("word not pushed");

    c_load: cover property (edg && ld);
    c_uni: cover property (edg && UNIDIR && i_shift_load);
    c_stall: cover property ($rose(o_overrun));
endmodule

bind ebusr_core ebusr_core_assertions #(.UNIDIR(UNIDIR)) u_ebusr_core_assertions (
    .i_mclk, .i_rst_b, .i_clear_b, .i_shift_clk, .i_mode_sel_zero, .i_mode_sel_one,
    .i_ser_right, .i_ser_left, .i_gate_clk_a, .i_gate_clk_b, .i_shift_load, .i_ser_j,
    .i_ser_k_b, .i_par_data, .o_stage, .o_word_valid, .o_word_data, .i_word_ready,
    .o_stalled, .o_overrun);

// [test/ebusr_sink.sv]
// Downstream word sink whose ready can be held off to stall the buffer.
`timescale 1ns/100ps
module ebusr_sink
(
    // Clock and reset
    input  wire logic i_mclk,
    input  wire logic i_rst_b,
    // Stall request and ready
    input  wire logic i_stall,
    output logic      o_ready
);
    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) o_ready <= 1'b0;
        else o_ready <= !i_stall;
    end
endmodule

// [test/tb_top.sv]
// Self-checking bench for both personalities of the shift register.
`timescale 1ns/100ps
module tb_top;
    import ebusr_pkg::*;
    logic       i_mclk, i_rst_b, i_clear_b, i_shift_clk, i_mode_sel_zero, i_mode_sel_one;
    logic       i_ser_right, i_ser_left, i_gate_clk_a, i_gate_clk_b, i_shift_load;
    logic       i_ser_j, i_ser_k_b, stall, bi_ready, uni_ready;
    logic [7:0] i_par_data, exp_b, exp_u;
    wire  [7:0] bi_stage, uni_stage, bi_wdata;
    wire        bi_first, bi_last, bi_stalled, bi_overrun, bi_wvalid;
    int         compares, miscompares;

    ebusr_core #(.UNIDIR(1'b0)) u_ebusr_core (
        .i_mclk, .i_rst_b, .i_clear_b, .i_shift_clk, .i_mode_sel_zero, .i_mode_sel_one,
        .i_ser_right, .i_ser_left, .i_gate_clk_a, .i_gate_clk_b, .i_shift_load, .i_ser_j,
        .i_ser_k_b, .i_par_data, .o_stage(bi_stage), .o_first_stage_out(bi_first),
        .o_last_stage_out(bi_last), .o_word_valid(bi_wvalid), .o_word_data(bi_wdata),
        .i_word_ready(bi_ready), .o_stalled(bi_stalled), .o_overrun(bi_overrun));
    ebusr_sink u_ebusr_sink (.i_mclk, .i_rst_b, .i_stall(stall), .o_ready(bi_ready));
    ebusr_core #(.UNIDIR(1'b1)) u_ebusr_core_uni (
        .i_mclk, .i_rst_b, .i_clear_b, .i_shift_clk, .i_mode_sel_zero, .i_mode_sel_one,
        .i_ser_right, .i_ser_left, .i_gate_clk_a, .i_gate_clk_b, .i_shift_load, .i_ser_j,
        .i_ser_k_b, .i_par_data, .o_stage(uni_stage), .o_first_stage_out(),
        .o_last_stage_out(), .o_word_valid(), .o_word_data(),
        .i_word_ready(uni_ready), .o_stalled(), .o_overrun());
    ebusr_sink u_ebusr_sink_uni (.i_mclk, .i_rst_b, .i_stall(stall), .o_ready(uni_ready));

    initial begin
        i_mclk = 1'b0;
        forever #12.5 i_mclk = ~i_mclk;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge i_mclk);
        #2;
    endtask
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic tally_and_finish;
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // Bidirectional step: controls change only while the clock pin is high.
    task automatic bstep(input logic s1, s0, r, l, input logic [7:0] d);
        {i_mode_sel_one, i_mode_sel_zero, i_ser_right, i_ser_left} = {s1, s0, r, l};
        i_par_data = d;
        tick(3);
        i_shift_clk = 1'b0;
        tick(3);
        i_shift_clk = 1'b1;
        tick(4);
        if (s1 && s0) exp_b = d;
        else if (s0) exp_b = {exp_b[6:0], r};
        else if (s1) exp_b = {l, exp_b[7:1]};
    endtask
    // Unidirectional step: both gates high first, then one gate clocks.
    task automatic ustep(input logic use_b, sl, j, kb, input logic [7:0] d);
        {i_gate_clk_a, i_gate_clk_b} = 2'b11;
        {i_shift_load, i_ser_j, i_ser_k_b} = {sl, j, kb};
        i_par_data = d;
        tick(3);
        {i_gate_clk_a, i_gate_clk_b} = 2'b00;
        tick(3);
        {i_gate_clk_a, i_gate_clk_b} = {!use_b, use_b};
        tick(4);
        if (!sl) exp_u = d;
        else exp_u = {exp_u[6:0], j ? (kb || !exp_u[0]) : (kb && exp_u[0])};
    endtask
    task automatic clear_pulse;
        i_clear_b = 1'b0;
        tick(4);
        chk(bi_stage, 8'h00);
        chk(uni_stage, 8'h00);
        chk({7'h00, bi_overrun}, 8'h00);
        i_clear_b = 1'b1;
        tick(3);
        exp_b = 8'h00;
        exp_u = 8'h00;
    endtask

    task automatic t_bidir;
        bstep(1, 1, 0, 0, 8'ha5);
        chk(bi_stage, exp_b);
        bstep(0, 1, 1, 0, 8'h00);
        chk(bi_stage, exp_b);
        chk({7'h00, bi_first}, {7'h00, exp_b[0]});
        bstep(1, 0, 0, 0, 8'h00);
        chk(bi_stage, exp_b);
        bstep(0, 0, 1, 1, 8'h3c);
        chk(bi_stage, exp_b);
        ustep(0, 0, 0, 0, 8'hff);
        clear_pulse();
    endtask
    task automatic t_far_end;
        bstep(0, 1, 1, 0, 8'h00);
        for (int i = 0; i < 6; i++) bstep(0, 1, 0, 0, 8'h00);
        chk({7'h00, bi_last}, 8'h00);
        bstep(0, 1, 0, 0, 8'h00);
        chk({7'h00, bi_last}, 8'h01);
    endtask
    task automatic t_unidir;
        ustep(0, 0, 0, 0, 8'h3c);
        chk(uni_stage, exp_u);
        for (int i = 0; i < 4; i++) begin
            ustep(i[0], 1, i[1], i[0], 8'hff);
            chk(uni_stage, exp_u);
        end
        {i_gate_clk_a, i_gate_clk_b} = 2'b11;
        tick(3);
        i_gate_clk_a = 1'b0;
        tick(3);
        i_gate_clk_a = 1'b1;
        tick(4);
        chk(uni_stage, exp_u);
    endtask
    task automatic t_stall;
        stall = 1'b1;
        tick(2);
        bstep(1, 1, 0, 0, 8'h11);
        bstep(1, 1, 0, 0, 8'h22);
        bstep(1, 1, 0, 0, 8'h33);
        chk({7'h00, bi_stalled}, 8'h01);
        chk(bi_stage, 8'h22);
        chk({7'h00, bi_wvalid}, 8'h01);
        chk(bi_wdata, 8'h11);
        bstep(1, 1, 0, 0, 8'h44);
        chk({7'h00, bi_overrun}, 8'h01);
        stall = 1'b0;
        tick(6);
        chk(bi_stage, 8'h33);
        chk({7'h00, bi_stalled}, 8'h00);
        clear_pulse();
    endtask

    initial begin
        {i_clear_b, i_shift_clk, i_gate_clk_a, i_gate_clk_b, i_shift_load} = 5'h1f;
        {i_mode_sel_zero, i_mode_sel_one, i_ser_right, i_ser_left} = 4'h0;
        {i_ser_j, i_ser_k_b, stall, i_rst_b} = 4'h0;
        {i_par_data, exp_b, exp_u} = 24'h000000;
        compares = 0;
        miscompares = 0;
        repeat (20) @(posedge i_mclk);
        #2;
        i_rst_b = 1'b1;
        tick(4);
        chk(bi_stage, EBUSR_STAGE_RST);
        t_bidir();
        t_far_end();
        t_unidir();
        t_stall();
        tally_and_finish();
    end

    initial begin
        repeat (100000) @(posedge i_mclk);
        miscompares++;
        tally_and_finish();
    end
endmodule
